// ---- gac_pkg.sv ----
// shared constants for the gain and attenuation pin control block
package gac_pkg;

    // -------------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------------
    localparam int NUM_PINS     = 19;
    localparam int NUM_GAIN_CH  = 8;  // 0..3 receive, 4..7 observation_receiver
    localparam int NUM_TX_CH    = 4;
    localparam int SEC_FRAME    = 16; // read flag, 7 address bits, 8 data bits
    localparam int SEC_HDR_BITS = 8;

    // -------------------------------------------------------------------
    // apb register byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_ATTEN_CFG  = 8'h04;
    localparam logic [7:0] ADDR_PIN_STATE  = 8'h08;
    localparam logic [7:0] ADDR_GAIN_CFG   = 8'h20; // + 4 * channel
    localparam logic [7:0] ADDR_GAIN_INDEX = 8'h40; // + 4 * channel
    localparam logic [7:0] ADDR_TX_ATTEN   = 8'h60; // + 4 * tx channel
    localparam logic [7:0] ADDR_ATTEN_AB   = 8'h70; // + 4 * tx channel

    // -------------------------------------------------------------------
    // control register fields
    // -------------------------------------------------------------------
    localparam int CTRL_SEC_ON     = 0;
    localparam int CTRL_SEL_PIN_LO = 4;  // 5 bits, 0 = unassigned, 4..18 valid
    localparam int CTRL_SEL_MASK_LO = 12; // 4 bits, tx channels on the select pin

    // -------------------------------------------------------------------
    // attenuation pin config fields
    // -------------------------------------------------------------------
    localparam int ATT_MASK_LO = 0;
    localparam int ATT_STEP_LO = 4;  // 5 bits, 0.5 dB per lsb
    localparam int ATT_UP_LO   = 12;
    localparam int ATT_DN_LO   = 16;
    localparam int ATT_EN      = 24;

    // -------------------------------------------------------------------
    // gain channel config fields
    // -------------------------------------------------------------------
    localparam int GCF_UP_STEP_LO = 0;
    localparam int GCF_DN_STEP_LO = 4;
    localparam int GCF_UP_PIN_LO  = 8;
    localparam int GCF_DN_PIN_LO  = 12;
    localparam int GCF_EN         = 16;
    localparam int GCF_MANUAL     = 17;

    // -------------------------------------------------------------------
    // secondary port address map and reset values
    // -------------------------------------------------------------------
    localparam logic [6:0] SEC_GAIN_BASE = 7'h00; // 8 gain indices
    localparam logic [6:0] SEC_ATT_A     = 7'h10; // 4 atten_state_a values
    localparam logic [6:0] SEC_ATT_B     = 7'h14; // 4 atten_state_b values
    localparam logic [7:0] GAIN_RST      = 8'hFF;
    localparam logic [7:0] ATTEN_RST     = 8'h00;
    localparam logic [4:0] SEL_MIN_PIN   = 5'd4;
    localparam logic [4:0] SEL_MAX_PIN   = 5'd18;

    // saturating step of an 8-bit value
    function automatic logic [7:0] step8(input logic [7:0] val, input logic [7:0] amt, input logic up);
        logic [8:0] sum;
        sum = 9'h000;
        if (up) begin
            sum = {1'b0, val} + {1'b0, amt};
            step8 = sum[8] ? 8'hFF : sum[7:0];
        end else begin
            step8 = (amt > val) ? 8'h00 : val - amt;
        end
    endfunction

endpackage

// ---- pin_pulse_sync.sv ----
// pin synchroniser with qualified rising-edge pulses
`timescale 1ns/1ps
module pin_pulse_sync (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         ce_i,
    // pins
    input  wire logic [gac_pkg::NUM_PINS-1:0] pin_i,
    // results
    output logic      [gac_pkg::NUM_PINS-1:0] level_o,
    output logic      [gac_pkg::NUM_PINS-1:0] rise_o
);
    import gac_pkg::*;

    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] s4;
    wire  [NUM_PINS-1:0] next_rise = s2 & s3 & ~s4;

    // ---------------------------------------------------------------
    // two flops, then a two-cycle-high qualifier
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            s2     <= '0;
            s3     <= '0;
            s4     <= '0;
            rise_o <= '0;
        end else if (ce_i) begin
            meta   <= pin_i;
            s2     <= meta;
            s3     <= s2;
            s4     <= s3;
            rise_o <= next_rise; // [R21] [R11]
        end
    end

    assign level_o = s2;

endmodule // pin_pulse_sync

// ---- gpio_gain_atten_pin_control.sv ----
// pin-driven gain index and transmit attenuation control with secondary serial port
//
// Functional notes
// R1: secondary port lives on pins 0 to 3
// R2: pin0 bidir data, pin1 out, pin2 clock, pin3 select
// R3: secondary port uses primary port framing settings
// R4: secondary port reaches only gain and attenuation
// R5: write/read gain index, program two atten states
// R6: select pin 4..18 toggles between atten states
// R7: enabled port overrides other pin functions there
// R8: port enable bit: 1 on, 0 off
// R9: several tx channels may share select pin
// R10: rising edge steps gain index up or down
// R11: processor holds gain pulses two clocks high
// R12: step fields 0..7 give steps 1..8
// R13: gain pins selectable from pins 0..15
// R14: stepping ignores reduced gain table range
// R15: per-channel pin control enable bit
// R16: gain stepping only in manual gain mode
// R17: atten pulse steps attenuation repeatably
// R18: atten pins selectable from pins 0..15
// R19: software never gives one pin two functions
// R20: atten step 0.5 dB per lsb, 0..31
// R21: pins synchronised, one step per pulse
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module gpio_gain_atten_pin_control (
    // clock, reset, enable
    input  wire logic                                  mclk_i,
    input  wire logic                                  nrst_i,
    input  wire logic                                  ce_i,
    // apb slave
    input  wire logic                                  psel_i,
    input  wire logic                                  penable_i,
    input  wire logic                                  pwrite_i,
    input  wire logic [7:0]                            paddr_i,
    input  wire logic [31:0]                           pwdata_i,
    output logic      [31:0]                           prdata_o,
    output logic                                       pready_o,
    output logic                                       pslverr_o,
    // framing settings of the primary serial port
    input  wire logic                                  prim_lsb_first_i,
    input  wire logic                                  prim_three_wire_i,
    // general-purpose pins
    input  wire logic [gac_pkg::NUM_PINS-1:0]          gpio_i,
    output logic      [gac_pkg::NUM_PINS-1:0]          gpio_o,
    output logic      [gac_pkg::NUM_PINS-1:0]          gpio_oe_o,
    // datapath controls
    output logic      [gac_pkg::NUM_GAIN_CH*8-1:0]     gain_index_o,
    output logic      [gac_pkg::NUM_TX_CH*8-1:0]       tx_atten_o
);
    import gac_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_m;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_rise;

    pin_pulse_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .pin_i   (gpio_i),
        .level_o (pin_lvl),
        .rise_o  (pin_rise)
    );

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic                sec_port_on;
    logic [4:0]          sel_pin;
    logic [3:0]          sel_mask;
    logic [3:0]          att_mask;
    logic [4:0]          att_step;
    logic [3:0]          att_up_pin;
    logic [3:0]          att_dn_pin;
    logic                att_en;
    logic [17:0]         gain_cfg  [NUM_GAIN_CH];
    logic [7:0]          gain_idx  [NUM_GAIN_CH];
    logic [7:0]          att_cur   [NUM_TX_CH];
    logic [7:0]          att_a     [NUM_TX_CH];
    logic [7:0]          att_b     [NUM_TX_CH];

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire        apb_setup = psel_i & ~penable_i;
    wire        apb_wr    = psel_i & penable_i & pwrite_i;
    wire [2:0]  a_idx     = paddr_i[4:2];
    wire [1:0]  t_idx     = paddr_i[3:2];
    wire        hit_ctrl  = paddr_i == ADDR_CTRL;
    wire        hit_attc  = paddr_i == ADDR_ATTEN_CFG;
    wire        hit_pins  = paddr_i == ADDR_PIN_STATE;
    wire        hit_gcfg  = paddr_i[7:5] == ADDR_GAIN_CFG[7:5] && paddr_i[1:0] == 2'b00;
    wire        hit_gidx  = paddr_i[7:5] == ADDR_GAIN_INDEX[7:5] && paddr_i[1:0] == 2'b00;
    wire        hit_tatt  = paddr_i[7:4] == ADDR_TX_ATTEN[7:4] && paddr_i[1:0] == 2'b00;
    wire        hit_ab    = paddr_i[7:4] == ADDR_ATTEN_AB[7:4] && paddr_i[1:0] == 2'b00;
    wire        hit_any   = hit_ctrl | hit_attc | hit_pins | hit_gcfg | hit_gidx | hit_tatt | hit_ab;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = {16'h0000, sel_mask, 3'b000, sel_pin, 3'b000, sec_port_on};
        end else if (hit_attc) begin
            rd_mux = {7'h00, att_en, 4'h0, att_dn_pin, att_up_pin, 3'b000, att_step, att_mask};
        end else if (hit_pins) begin
            rd_mux = {13'h0000, pin_lvl};
        end else if (hit_gcfg) begin
            rd_mux = {14'h0000, gain_cfg[a_idx]};
        end else if (hit_gidx) begin
            rd_mux = {24'h00_0000, gain_idx[a_idx]};
        end else if (hit_tatt) begin
            rd_mux = {24'h00_0000, att_cur[t_idx]};
        end else if (hit_ab) begin
            rd_mux = {16'h0000, att_b[t_idx], att_a[t_idx]};
        end
    end

    // zero-wait slave: data latched in setup, valid through access
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end else if (ce_i && apb_setup) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
            pready_o  <= 1'b1;
            pslverr_o <= ~hit_any;
        end
    end

    // ---------------------------------------------------------------
    // pins taken over by the secondary port
    // ---------------------------------------------------------------
    wire                sel_valid = sel_pin >= SEL_MIN_PIN && sel_pin <= SEL_MAX_PIN;
    wire [NUM_PINS-1:0] sel_onehot = sel_valid ? (19'h00001 << sel_pin) : 19'h00000;
    wire [NUM_PINS-1:0] owned = sec_port_on ? (sel_onehot | 19'h0000F) : 19'h00000; // [R7]
    wire [NUM_PINS-1:0] pulse = pin_rise & ~owned; // [R7]
    wire                sel_lvl = |(pin_lvl & sel_onehot);

    // ---------------------------------------------------------------
    // secondary serial port on pins 0..3
    // ---------------------------------------------------------------
    wire sclk_lvl = pin_lvl[2]; // [R2]
    wire cs_lvl   = pin_lvl[3]; // [R2]
    wire din_lvl  = pin_lvl[0]; // [R2]
    logic        sclk_prev;
    logic [4:0]  bit_cnt;
    logic [7:0]  hdr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    wire         active   = sec_port_on & ~cs_lvl; // [R1] [R8]
    wire         sclk_up  = active & sclk_lvl & ~sclk_prev;
    wire         sclk_dn  = active & ~sclk_lvl & sclk_prev;
    wire         in_hdr   = bit_cnt < 5'(SEC_HDR_BITS);
    wire [2:0]   bpos     = prim_lsb_first_i ? bit_cnt[2:0] : 3'd7 - bit_cnt[2:0]; // [R3]
    wire [7:0]   next_hdr = in_hdr ? (hdr | ({7'h00, din_lvl} << bpos)) : hdr;
    wire [7:0]   next_wdat = in_hdr ? wdat : (wdat | ({7'h00, din_lvl} << bpos));
    wire         last_bit = sclk_up && bit_cnt == 5'(SEC_FRAME - 1);
    wire         sec_wr   = last_bit & ~hdr[7];
    wire [6:0]   sec_addr = hdr[6:0];
    wire         hdr_done = sclk_up && bit_cnt == 5'(SEC_HDR_BITS - 1);

    // reach limited to gain indices and the two attenuation states
    function automatic logic [7:0] sec_lookup(input logic [6:0] adr);
        sec_lookup = 8'h00;
        if (adr[6:3] == SEC_GAIN_BASE[6:3]) begin
            sec_lookup = gain_idx[adr[2:0]];
        end else if (adr[6:2] == SEC_ATT_A[6:2]) begin
            sec_lookup = att_a[adr[1:0]];
        end else if (adr[6:2] == SEC_ATT_B[6:2]) begin
            sec_lookup = att_b[adr[1:0]];
        end
    endfunction

    wire [7:0] hdr_full = next_hdr;
    wire       is_read  = hdr[7] & ~in_hdr;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev <= 1'b0;
            bit_cnt   <= 5'd0;
            hdr       <= 8'h00;
            wdat      <= 8'h00;
            rdat      <= 8'h00;
        end else if (ce_i) begin
            sclk_prev <= sclk_lvl;
            if (!active) begin
                bit_cnt <= 5'd0;
                hdr     <= 8'h00;
                wdat    <= 8'h00;
            end else if (sclk_up) begin
                bit_cnt <= bit_cnt + 5'd1;
                hdr     <= next_hdr;
                wdat    <= next_wdat;
                if (hdr_done) begin
                    rdat <= sec_lookup(hdr_full[6:0]); // [R4] [R5]
                end
            end
        end
    end

    // read data shifted on falling clock; three-wire returns it on pin 0
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            gpio_o    <= '0;
            gpio_oe_o <= '0;
        end else if (ce_i) begin
            if (!active) begin
                gpio_oe_o <= '0;
                gpio_o    <= '0;
            end else if (sclk_dn && is_read && bit_cnt < 5'(SEC_FRAME)) begin
                gpio_o[0]    <= rdat[bpos]; // [R2]
                gpio_o[1]    <= rdat[bpos]; // [R2]
                gpio_oe_o[0] <= prim_three_wire_i; // [R3]
                gpio_oe_o[1] <= ~prim_three_wire_i;
            end else if (sclk_dn && !is_read) begin
                gpio_oe_o <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // gain index stepping, apb and secondary port writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NUM_GAIN_CH; c++) begin
                gain_cfg[c] <= 18'h00000;
                gain_idx[c] <= GAIN_RST;
            end
        end else if (ce_i) begin
            for (int c = 0; c < NUM_GAIN_CH; c++) begin
                logic [3:0] up_p;
                logic [3:0] dn_p;
                logic       go;
                up_p = gain_cfg[c][GCF_UP_PIN_LO +: 4]; // [R13]
                dn_p = gain_cfg[c][GCF_DN_PIN_LO +: 4]; // [R13]
                go   = gain_cfg[c][GCF_EN] & gain_cfg[c][GCF_MANUAL]; // [R15] [R16]
                if (sec_wr && sec_addr[6:3] == SEC_GAIN_BASE[6:3] && sec_addr[2:0] == 3'(c)) begin
                    gain_idx[c] <= next_wdat; // [R5]
                end else if (apb_wr && hit_gidx && a_idx == 3'(c)) begin
                    gain_idx[c] <= pwdata_i[7:0];
                end else if (go && pulse[up_p] && !pulse[dn_p]) begin
                    // full table limits only, no useful-range clamp
                    gain_idx[c] <= step8(gain_idx[c], {5'h00, gain_cfg[c][GCF_UP_STEP_LO +: 3]} + 8'h01, 1'b1); // [R10] [R12] [R14]
                end else if (go && pulse[dn_p] && !pulse[up_p]) begin
                    gain_idx[c] <= step8(gain_idx[c], {5'h00, gain_cfg[c][GCF_DN_STEP_LO +: 3]} + 8'h01, 1'b0); // [R10] [R12] [R14]
                end
                if (apb_wr && hit_gcfg && a_idx == 3'(c)) begin
                    gain_cfg[c] <= {pwdata_i[17:16], pwdata_i[15:8], 1'b0, pwdata_i[6:4], 1'b0, pwdata_i[2:0]};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // control and attenuation configuration
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sec_port_on <= 1'b0;
            sel_pin     <= 5'd0;
            sel_mask    <= 4'h0;
            att_mask    <= 4'h0;
            att_step    <= 5'd0;
            att_up_pin  <= 4'h0;
            att_dn_pin  <= 4'h0;
            att_en      <= 1'b0;
        end else if (ce_i && apb_wr) begin
            if (hit_ctrl) begin
                sec_port_on <= pwdata_i[CTRL_SEC_ON]; // [R8]
                sel_pin     <= pwdata_i[CTRL_SEL_PIN_LO +: 5]; // [R6]
                sel_mask    <= pwdata_i[CTRL_SEL_MASK_LO +: 4]; // [R9]
            end
            if (hit_attc) begin
                att_mask    <= pwdata_i[ATT_MASK_LO +: 4];
                att_step    <= pwdata_i[ATT_STEP_LO +: 5]; // [R20]
                att_up_pin  <= pwdata_i[ATT_UP_LO +: 4]; // [R18]
                att_dn_pin  <= pwdata_i[ATT_DN_LO +: 4]; // [R18]
                att_en      <= pwdata_i[ATT_EN];
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit attenuation: pulse stepping and the two states
    // ---------------------------------------------------------------
    wire att_up = att_en & pulse[att_up_pin] & ~pulse[att_dn_pin];
    wire att_dn = att_en & pulse[att_dn_pin] & ~pulse[att_up_pin];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < NUM_TX_CH; t++) begin
                att_cur[t] <= ATTEN_RST;
                att_a[t]   <= ATTEN_RST;
                att_b[t]   <= ATTEN_RST;
            end
        end else if (ce_i) begin
            for (int t = 0; t < NUM_TX_CH; t++) begin
                if (apb_wr && hit_tatt && t_idx == 2'(t)) begin
                    att_cur[t] <= pwdata_i[7:0];
                end else if (att_mask[t] && att_up) begin
                    att_cur[t] <= step8(att_cur[t], {3'b000, att_step}, 1'b1); // [R17] [R20]
                end else if (att_mask[t] && att_dn) begin
                    att_cur[t] <= step8(att_cur[t], {3'b000, att_step}, 1'b0); // [R17] [R20]
                end
                if (sec_wr && sec_addr == SEC_ATT_A + 7'(t)) begin
                    att_a[t] <= next_wdat; // [R5]
                end else if (apb_wr && hit_ab && t_idx == 2'(t)) begin
                    att_a[t] <= pwdata_i[7:0];
                end
                if (sec_wr && sec_addr == SEC_ATT_B + 7'(t)) begin
                    att_b[t] <= next_wdat; // [R5]
                end else if (apb_wr && hit_ab && t_idx == 2'(t)) begin
                    att_b[t] <= pwdata_i[15:8];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // registered datapath outputs
    // ---------------------------------------------------------------
    wire sel_use = sec_port_on & sel_valid;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            gain_index_o <= {NUM_GAIN_CH{GAIN_RST}};
            tx_atten_o   <= {NUM_TX_CH{ATTEN_RST}};
        end else if (ce_i) begin
            for (int c = 0; c < NUM_GAIN_CH; c++) begin
                gain_index_o[c*8 +: 8] <= gain_idx[c];
            end
            for (int t = 0; t < NUM_TX_CH; t++) begin
                if (sel_use && sel_mask[t]) begin
                    tx_atten_o[t*8 +: 8] <= sel_lvl ? att_b[t] : att_a[t]; // [R6] [R9]
                end else begin
                    tx_atten_o[t*8 +: 8] <= att_cur[t];
                end
            end
        end
    end

endmodule // gpio_gain_atten_pin_control

// ---- gac_monitor.sv ----
// checker for the pin control block ports
`timescale 1ns/1ps
module gac_monitor (
    // clock, reset, apb
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // pins and controls
    input wire logic [18:0] gpio_i,
    input wire logic [18:0] gpio_o,
    input wire logic [18:0] gpio_oe_o,
    input wire logic [63:0] gain_index_o,
    input wire logic [31:0] tx_atten_o
);
    wire       acc    = psel_i && penable_i;
    wire       mapped = paddr_i[1:0] == 2'h0 && (paddr_i < 8'h0C || (paddr_i >= 8'h20 && paddr_i < 8'h80));
    logic [3:0] quiet;
    // cycles since the last pin change or bus access
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) quiet <= 4'h0;
        else if (psel_i || $changed(gpio_i)) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_bad_addr: assert property (acc && !mapped |-> pslverr_o) else $error("no error on unmapped");
    a_good_addr: assert property (acc && mapped |-> !pslverr_o) else $error("error on mapped");
    a_write_zero: assert property (acc && pwrite_i |-> prdata_o == 32'h0) else $error("read data on write");
    a_rdata_hold: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o)) else $error("rdata moved");
    a_oe_upper: assert property (gpio_oe_o[18:2] == 17'h0) else $error("upper pin driven");
    a_out_upper: assert property (gpio_o[18:2] == 17'h0) else $error("upper pin output");
    a_gain_quiet: assert property (quiet >= 4'd10 |-> $stable(gain_index_o)) else $error("gain moved");
    a_atten_quiet: assert property (quiet >= 4'd10 |-> $stable(tx_atten_o)) else $error("atten moved");
    c_read: cover property (acc && !pwrite_i);
    c_err: cover property (pslverr_o);
    c_step: cover property ($changed(gain_index_o) && !psel_i);
endmodule // gac_monitor

// ---- gac_bb_model.sv ----
// baseband processor model driving the control pins
`timescale 1ns/1ps
module gac_bb_model (
    // clock
    input  wire logic        mclk_i,
    // pins toward the device
    output logic      [18:0] pins_o,
    // pins from the device
    input  wire logic [18:0] dout_i
);
    // chip select of the secondary port idles high
    initial pins_o = 19'h00008;
    // high for n cycles, then low long enough before the next pulse
    task automatic pulse(input int p, input int n);
        @(posedge mclk_i) pins_o[p] <= 1'b1;
        repeat (n) @(posedge mclk_i);
        pins_o[p] <= 1'b0;
        repeat (12) @(posedge mclk_i);
    endtask
    // one 16-bit frame on pins 0..3, msb first, read data taken from pin 1
    task automatic frame(input logic [15:0] w, output logic [7:0] r);
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk_i) pins_o[3:0] <= {3'b000, w[i]};
            repeat (4) @(posedge mclk_i);
            r = {r[6:0], dout_i[1]};
            pins_o[2] <= 1'b1;
            repeat (4) @(posedge mclk_i);
        end
        @(posedge mclk_i) pins_o[3:0] <= 4'h8;
        repeat (8) @(posedge mclk_i);
    endtask
    task automatic level(input int p, input logic v);
        @(posedge mclk_i) pins_o[p] <= v;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule // gac_bb_model

// ---- gpio_gain_atten_pin_control_tb.sv ----
// self-checking bench for the pin control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module gpio_gain_atten_pin_control_tb;
    import gac_pkg::*;
    logic        mclk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
    logic [7:0]  paddr = 0, sr;
    logic [31:0] pwdata = 0, rd, prdata, att;
    logic [63:0] gain;
    logic [18:0] pins, gout;
    int          num_errors = 0, n_tests = 0;
    always #12.5 mclk_i = ~mclk_i;
    gpio_gain_atten_pin_control i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .prim_lsb_first_i(1'b0), .prim_three_wire_i(1'b0),
        .gpio_i(pins), .gpio_o(gout), .gpio_oe_o(), .gain_index_o(gain), .tx_atten_o(att));
    gac_bb_model i_bb (.mclk_i(mclk_i), .pins_o(pins), .dout_i(gout));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_i) penable <= 1;
        do begin @(posedge mclk_i); k++; end while (pready !== 1'b1 && k < 50);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
        if (k >= 50) num_errors++;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
        apb(0, a, 32'h0);
        `CHK("prdata", ex, rd)
    endtask
    task automatic t_regs;
        `CHK("gain rst", {NUM_GAIN_CH{GAIN_RST}}, gain)
        `CHK("att rst", {NUM_TX_CH{ATTEN_RST}}, att)
        apb(0, 8'h0C, 32'h0);
        `CHK("err", 1'b1, er)
        apb(1, ADDR_GAIN_CFG + 8'h04, 32'h0003_6527);
        rdchk(ADDR_GAIN_CFG + 8'h04, 32'h0003_6527);
    endtask
    task automatic t_gain;
        apb(1, ADDR_GAIN_INDEX + 8'h04, 32'hC4);
        i_bb.pulse(6, 2);
        `CHK("gain dn", 8'hC1, gain[15:8])
        i_bb.pulse(6, 1);
        `CHK("gain short", 8'hC1, gain[15:8])
        i_bb.pulse(5, 3);
        `CHK("gain up", 8'hC9, gain[15:8])
        `CHK("gain ch0", 8'hFF, gain[7:0])
        apb(1, ADDR_GAIN_CFG + 8'h04, 32'h0001_6527);
        i_bb.pulse(5, 2);
        rdchk(ADDR_GAIN_INDEX + 8'h04, 32'hC9);
        apb(1, ADDR_GAIN_CFG + 8'h04, 32'h0002_6527);
        i_bb.pulse(5, 2);
        rdchk(ADDR_GAIN_INDEX + 8'h04, 32'hC9);
    endtask
    task automatic t_atten;
        apb(1, ADDR_ATTEN_CFG, 32'h0108_71F5);
        repeat (2) i_bb.pulse(7, 2);
        `CHK("att up", 32'h003E_003E, att)
        i_bb.pulse(8, 2);
        rdchk(ADDR_TX_ATTEN + 8'h08, 32'h1F);
    endtask
    task automatic t_select;
        apb(1, ADDR_ATTEN_AB + 8'h0C, 32'h2211);
        apb(1, ADDR_CTRL, 32'h8091);
        i_bb.level(9, 0);
        `CHK("sel lo", 32'h111F_001F, att)
        i_bb.level(9, 1);
        `CHK("sel hi", 8'h22, att[31:24])
        apb(1, ADDR_GAIN_CFG + 8'h04, 32'h0003_6023);
        i_bb.pulse(0, 2);
        rdchk(ADDR_GAIN_INDEX + 8'h04, 32'hC9);
        i_bb.frame(16'h01A5, sr);
        rdchk(ADDR_GAIN_INDEX + 8'h04, 32'hA5);
        i_bb.frame(16'h8100, sr);
        `CHK("sec rd", 8'hA5, sr)
        i_bb.frame(16'h175A, sr);
        `CHK("sec att", 8'h5A, att[31:24])
        apb(1, ADDR_CTRL, 32'h0);
        i_bb.level(9, 0);
        `CHK("sel off", 8'h00, att[31:24])
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1;
        repeat (3) @(posedge mclk_i);
        t_regs; t_gain; t_atten; t_select;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        give_verdict;
    end
endmodule // gpio_gain_atten_pin_control_tb
bind gpio_gain_atten_pin_control gac_monitor i_mon (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
    .gain_index_o(gain_index_o), .tx_atten_o(tx_atten_o));
